// *** testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic        clock_i, reset_n_i, tick_i, psel_i, penable_i, pwrite_i, dir_q, err, pin_a, pw;
   logic        pready_o, pslverr_o, wave_out_a_o, wave_out_b_o, wave_en_a_o, wave_en_b_o;
   logic        overflow_flag_o, match_flag_a_o, match_flag_b_o;
   logic [7:0]  paddr_i, count_value_o, pc, top, c;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic [2:0]  modes [4] = '{3'h1, 3'h3, 3'h5, 3'h7};
   int          mismatches, compares, cycles, t, h, len;

   tmw_timer DUT (.clock_i, .reset_n_i, .tick_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .wave_out_a_o, .wave_out_b_o, .wave_en_a_o,
      .wave_en_b_o, .overflow_flag_o, .match_flag_a_o, .match_flag_b_o, .count_value_o);
   tmw_pin_load u_pin (.dir_out_i(dir_q), .wave_en_i(wave_en_a_o), .wave_i(wave_out_a_o), .pin_o(pin_a));

   // ----------------------------------------------------------------------------
   // clock, timeout and helpers
   // ----------------------------------------------------------------------------
   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end

   // a hang ends the run well after the longest expected sequence
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 60000) begin
         mismatches++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // apb transfer: hold everything until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= wr;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge clock_i) penable_i <= 1'b1;
      do @(posedge clock_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clock_i);
   endtask

   // samples n cycles: time the pin is high and the largest count seen
   task automatic run(input int n);
      h = 0;
      top = 8'h00;
      repeat (n) begin
         @(posedge clock_i);
         h += (pin_a === 1'b1);
         if (count_value_o > top) top = count_value_o;
      end
   endtask

   // high cycles per period: fast is c+1 of 256, dual slope 2c of 510
   function automatic int exp_high(logic [2:0] m, logic [1:0] com, logic [7:0] cv);
      int n;
      n = m[1] ? int'(cv) + 1 : 2 * int'(cv);
      if (com == 2'h3) n = (m[1] ? 256 : 510) - n;
      return n;
   endfunction

   // ----------------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------------
   initial begin
      {reset_n_i, tick_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
      {mismatches, compares, cycles} = '0;
      dir_q = 1'b1;
      void'($urandom(60343));
      repeat (2) @(posedge clock_i);
      reset_n_i <= 1'b1;
      @(posedge clock_i);
      // stopped timer still takes count writes; unmapped place is refused
      apb(1'b1, tmw_pkg::ADDR_CTRL, 32'h0000_0100);
      apb(1'b1, tmw_pkg::ADDR_COUNT, 32'h0000_0055);
      tick_i <= 1'b1;
      repeat (20) @(posedge clock_i);
      tick_i <= 1'b0;
      apb(1'b0, tmw_pkg::ADDR_COUNT, 32'h0);
      chk(rd, 32'h0000_0055, "stopped count");
      apb(1'b0, 8'h20, 32'h0);
      chk(err, 1'b1, "unmapped");
      dir_q <= 1'b0;
      @(posedge clock_i);
      chk(pin_a, 1'b1, "pin input");
      dir_q <= 1'b1;
      // normal mode under random ticks
      apb(1'b1, tmw_pkg::ADDR_CTRL, 32'h0000_0010);
      apb(1'b1, tmw_pkg::ADDR_COUNT, 32'h0000_00f0);
      apb(1'b1, tmw_pkg::ADDR_FLAGS, 32'h0000_0007);
      t = 0;
      repeat (200) begin
         tick_i <= 1'($urandom);
         @(posedge clock_i);
         t += tick_i;
      end
      tick_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      chk(count_value_o, 8'(8'hf0 + t), "normal count");
      chk(overflow_flag_o, 1'(t >= 16), "normal ovf");
      // clear-on-match, compare below the start count, toggling output
      apb(1'b1, tmw_pkg::ADDR_CTRL, 32'h0000_0d12);
      apb(1'b1, tmw_pkg::ADDR_CMPA, 32'h0000_0003);
      apb(1'b1, tmw_pkg::ADDR_COUNT, 32'h0000_0010);
      apb(1'b1, tmw_pkg::ADDR_FLAGS, 32'h0000_0007);
      tick_i <= 1'b1;
      @(posedge clock_i);
      pc = count_value_o;
      pw = wave_out_a_o;
      repeat (300) begin
         @(posedge clock_i);
         chk(count_value_o, (pc == 8'h03 || pc == 8'hff) ? 8'h00 : 8'(pc + 8'h01), "ctc count");
         chk(wave_out_a_o, pw ^ (pc == 8'h03), "ctc toggle");
         pc = count_value_o;
         pw = wave_out_a_o;
      end
      tick_i <= 1'b0;
      chk(match_flag_a_o, 1'b1, "ctc match");
      chk(overflow_flag_o, 1'b1, "ctc ovf");
      // compare b keeps its reset value of zero, so the pass through zero sets its flag and level
      chk(match_flag_b_o, 1'b1, "ctc match b");
      chk({wave_en_b_o, wave_out_b_o}, 2'h3, "ctc set b");
      // pwm modes, both polarities, extreme and random compare values
      for (int i = 0; i < 24; i++) begin
         c = (i % 6 < 2) ? 8'h00 : (i % 6 < 4) ? 8'hff : 8'($urandom);
         apb(1'b1, tmw_pkg::ADDR_CTRL, {22'h0, 2'h2 + 2'(i % 2), 5'h02, modes[i / 6]});
         apb(1'b1, tmw_pkg::ADDR_CMPA, {24'h0, c});
         apb(1'b1, tmw_pkg::ADDR_COUNT, 32'h0);
         apb(1'b1, tmw_pkg::ADDR_FLAGS, 32'h0000_0007);
         len = modes[i / 6][1] ? 256 : 510;
         tick_i <= 1'b1;
         run(2 * len);
         run(len);
         tick_i <= 1'b0;
         chk(top, modes[i / 6][2] ? c : 8'hff, "pwm top");
         if (!modes[i / 6][2]) chk(h, exp_high(modes[i / 6], 2'h2 + 2'(i % 2), c), "duty");
         chk(overflow_flag_o, 1'b1, "pwm ovf");
      end
      // fast pwm toggle with top 7: square wave of 16 cycles, half of them high
      apb(1'b1, tmw_pkg::ADDR_CTRL, 32'h0000_0117);
      apb(1'b1, tmw_pkg::ADDR_CMPA, 32'h0000_0007);
      apb(1'b1, tmw_pkg::ADDR_COUNT, 32'h0);
      tick_i <= 1'b1;
      run(300);
      run(64);
      tick_i <= 1'b0;
      chk(h, 32, "fast toggle");
      give_verdict();
   end
endmodule
`default_nettype wire

// *** tmw_pin_load.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// port pin with a pull-up, driven by one compare output
// ----------------------------------------------------------------------------
module tmw_pin_load (
   input  wire logic dir_out_i,  // pin direction bit, 1 = output
   input  wire logic wave_en_i,  // compare output owns the pin
   input  wire logic wave_i,     // compare output level
   output logic      pin_o       // level seen by the load
);
   // the wave shows only with the driver on; otherwise the pull-up wins
   assign pin_o = (dir_out_i && wave_en_i) ? wave_i : 1'b1;
endmodule
`default_nettype wire

// *** tmw_pkg.sv ***
`default_nettype none
// ----------------------------------------------------------------------------
// constants and state layout of the 8-bit waveform timer
// ----------------------------------------------------------------------------
package tmw_pkg;

   // apb register byte offsets
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_COUNT  = 8'h04;
   localparam logic [7:0] ADDR_CMPA   = 8'h08;
   localparam logic [7:0] ADDR_CMPB   = 8'h0c;
   localparam logic [7:0] ADDR_FLAGS  = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;

   // control register field positions
   localparam int CTRL_WAVE_LSB = 0;   // wave_mode_sel, 3 bits
   localparam int CTRL_CS_LSB   = 4;   // clock_source_sel, 3 bits
   localparam int CTRL_COMA_LSB = 8;   // compare_out_mode_a, 2 bits
   localparam int CTRL_COMB_LSB = 10;  // compare_out_mode_b, 2 bits

   // flag and status bit positions
   localparam int FLAG_OVF     = 0;
   localparam int FLAG_MATCH_A = 1;
   localparam int FLAG_MATCH_B = 2;
   localparam int STAT_WAVE_A  = 0;
   localparam int STAT_WAVE_B  = 1;
   localparam int STAT_DOWN    = 2;

   // count extremes and reset values
   localparam logic [7:0] CNT_MAX    = 8'hff;
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam logic [2:0] CS_STOPPED = 3'h0;

   typedef enum logic [2:0] {
      WM_NORMAL    = 3'h0,
      WM_PC_FULL   = 3'h1,
      WM_CTC       = 3'h2,
      WM_FAST_FULL = 3'h3,
      WM_RSV4      = 3'h4,
      WM_PC_CMPA   = 3'h5,
      WM_RSV6      = 3'h6,
      WM_FAST_CMPA = 3'h7
   } tmw_wave_mode_t;

   typedef enum logic [1:0] {
      COM_OFF    = 2'h0,
      COM_TOGGLE = 2'h1,
      COM_CLEAR  = 2'h2,
      COM_SET    = 2'h3
   } tmw_out_mode_t;

   typedef struct packed {
      tmw_wave_mode_t      wave_mode;
      logic [2:0]          clk_sel;
      tmw_out_mode_t [1:0] out_mode;
      logic [1:0]          wave_en;
      logic [7:0]          count;
      logic                count_down;
      logic [1:0][7:0]     cmp_buf;
      logic [1:0][7:0]     cmp_act;
      logic                match_block;
      logic                ovf_flag;
      logic [1:0]          match_flag;
      logic [1:0]          wave;
      logic                pready;
      logic                pslverr;
      logic [31:0]         prdata;
   } tmw_state_t;

endpackage
`default_nettype wire

// *** tmw_timer.sv ***
// What this block does
// - wave mode picks the count sequence; output mode only shapes outputs.
// - mode 0 always increments, never clears on match, wraps 0xFF to 0x00.
// - normal mode sets overflow flag as count becomes zero; only sets it.
// - mode 2 clears the counter when it matches compare value A.
// - clear-on-match writes compare A directly; a lower value waits for a wrap.
// - clear-on-match raises match flag A at each top match.
// - clear-on-match output mode 1 toggles output A on each match.
// - clear-on-match still sets overflow on the 0xFF to 0x00 pass.
// - modes 3 and 7 are fast PWM, top 0xFF or compare value A.
// - fast PWM clears the counter on the tick after it equals top.
// - fast PWM non-inverting clears on match, sets at bottom; inverting opposite.
// - fast PWM sets the overflow flag whenever the counter reaches top.
// - fast PWM compare zero gives one-tick spike; compare max gives constant level.
// - fast PWM output mode 1 toggles output A on match in mode 7 only, buffering kept.
// - modes 1 and 5 are phase-correct PWM, counting up then down.
// - phase-correct counter holds top for exactly one tick when reversing.
// - phase-correct non-inverting clears on up match, sets on down match.
// - phase-correct sets the overflow flag whenever the counter reaches zero.
// - phase-correct compare zero holds low, compare max holds high, non-inverted.
// - phase-correct output takes its start level at bottom without a match.
// - PWM modes buffer compare writes until top; others apply them at once.
// - clock select zero stops counting; count stays readable and writable.
`timescale 1ns/100ps
`default_nettype none
module tmw_timer (
   input  wire logic        clock_i,          // 200 mhz system clock
   input  wire logic        reset_n_i,        // synchronous reset, active low
   input  wire logic        tick_i,           // timer clock enable from prescaler
   input  wire logic        psel_i,           // apb select
   input  wire logic        penable_i,        // apb access phase
   input  wire logic        pwrite_i,         // apb write
   input  wire logic [7:0]  paddr_i,          // apb byte address
   input  wire logic [31:0] pwdata_i,         // apb write data
   output logic      [31:0] prdata_o,         // apb read data
   output logic             pready_o,         // apb ready
   output logic             pslverr_o,        // apb error, unmapped address
   output logic             wave_out_a_o,     // compare output a level
   output logic             wave_out_b_o,     // compare output b level
   output logic             wave_en_a_o,      // output a overrides port pin
   output logic             wave_en_b_o,      // output b overrides port pin
   output logic             overflow_flag_o,  // sticky overflow flag
   output logic             match_flag_a_o,   // sticky match flag a
   output logic             match_flag_b_o,   // sticky match flag b
   output logic      [7:0]  count_value_o     // current count
);

   // ------------------------------------------------------------------------
   // mode decoding
   // ------------------------------------------------------------------------

   // pwm modes buffer compare writes
   function automatic logic mode_is_pwm(input tmw_pkg::tmw_wave_mode_t m);
      mode_is_pwm = (m == tmw_pkg::WM_PC_FULL) || (m == tmw_pkg::WM_FAST_FULL) ||
                    (m == tmw_pkg::WM_PC_CMPA) || (m == tmw_pkg::WM_FAST_CMPA);
   endfunction

   function automatic logic mode_is_pc(input tmw_pkg::tmw_wave_mode_t m);
      mode_is_pc = (m == tmw_pkg::WM_PC_FULL) || (m == tmw_pkg::WM_PC_CMPA);
   endfunction

   function automatic logic mode_is_fast(input tmw_pkg::tmw_wave_mode_t m);
      mode_is_fast = (m == tmw_pkg::WM_FAST_FULL) || (m == tmw_pkg::WM_FAST_CMPA);
   endfunction

   // top is compare a in modes 2, 5 and 7, else the full count
   function automatic logic [7:0] mode_top(input tmw_pkg::tmw_wave_mode_t m,
                                           input logic [7:0] cmp_a);
      if ((m == tmw_pkg::WM_CTC) || (m == tmw_pkg::WM_PC_CMPA) || (m == tmw_pkg::WM_FAST_CMPA)) begin
         mode_top = cmp_a;
      end else begin
         mode_top = tmw_pkg::CNT_MAX;
      end
   endfunction

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == tmw_pkg::ADDR_CTRL) || (a == tmw_pkg::ADDR_COUNT) ||
                (a == tmw_pkg::ADDR_CMPA) || (a == tmw_pkg::ADDR_CMPB) ||
                (a == tmw_pkg::ADDR_FLAGS) || (a == tmw_pkg::ADDR_STATUS);
   endfunction

   // ------------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------------
   tmw_pkg::tmw_state_t s_q;
   tmw_pkg::tmw_state_t s_d;

   logic       tick;       // timer advances this cycle
   logic       wr_en;      // apb write takes effect this cycle
   logic       wr_count;   // software writes the count
   logic [7:0] top;        // current top value
   logic [1:0] match;      // unblocked compare match per channel
   logic       ovf_set;    // overflow event this tick

   // ------------------------------------------------------------------------
   // next state: apb slave, counter, compare and wave logic
   // ------------------------------------------------------------------------
   always_comb begin
      logic        pwm;
      logic        pc;
      logic        fast;
      logic        at_top;
      logic        at_bot;
      logic        ignore;
      logic        can_toggle;
      logic [31:0] rd;
      pwm        = mode_is_pwm(s_q.wave_mode);
      pc         = mode_is_pc(s_q.wave_mode);
      fast       = mode_is_fast(s_q.wave_mode);
      at_top     = 1'b0;
      at_bot     = 1'b0;
      ignore     = 1'b0;
      can_toggle = 1'b0;
      rd         = 32'h0000_0000;
      s_d        = s_q;

      // a stopped clock source holds the counter still
      tick     = tick_i && (s_q.clk_sel != tmw_pkg::CS_STOPPED);
      wr_en    = psel_i && penable_i && pwrite_i && s_q.pready;
      wr_count = wr_en && (paddr_i == tmw_pkg::ADDR_COUNT);
      top      = mode_top(s_q.wave_mode, s_q.cmp_act[0]);
      ovf_set  = 1'b0;
      for (int ch = 0; ch < 2; ch++) begin
         match[ch] = (s_q.count == s_q.cmp_act[ch]) && !s_q.match_block;
      end

      // apb: no wait states, ready and read data registered at setup
      case (paddr_i)
         tmw_pkg::ADDR_CTRL: begin
            rd[tmw_pkg::CTRL_WAVE_LSB +: 3] = s_q.wave_mode;
            rd[tmw_pkg::CTRL_CS_LSB +: 3]   = s_q.clk_sel;
            rd[tmw_pkg::CTRL_COMA_LSB +: 2] = s_q.out_mode[0];
            rd[tmw_pkg::CTRL_COMB_LSB +: 2] = s_q.out_mode[1];
         end
         tmw_pkg::ADDR_COUNT: rd[7:0] = s_q.count;
         tmw_pkg::ADDR_CMPA:  rd[7:0] = s_q.cmp_buf[0];
         tmw_pkg::ADDR_CMPB:  rd[7:0] = s_q.cmp_buf[1];
         tmw_pkg::ADDR_FLAGS: begin
            rd[tmw_pkg::FLAG_OVF]     = s_q.ovf_flag;
            rd[tmw_pkg::FLAG_MATCH_A] = s_q.match_flag[0];
            rd[tmw_pkg::FLAG_MATCH_B] = s_q.match_flag[1];
         end
         tmw_pkg::ADDR_STATUS: begin
            rd[tmw_pkg::STAT_WAVE_A] = s_q.wave[0];
            rd[tmw_pkg::STAT_WAVE_B] = s_q.wave[1];
            rd[tmw_pkg::STAT_DOWN]   = s_q.count_down;
         end
         default: rd = 32'h0000_0000;
      endcase
      s_d.pready  = psel_i && !penable_i;
      s_d.pslverr = psel_i && !penable_i && !addr_ok(paddr_i);
      s_d.prdata  = (psel_i && !penable_i && !pwrite_i) ? rd : 32'h0000_0000;

      // counter sequence depends on wave mode only, never on output mode
      if (tick) begin
         s_d.match_block = 1'b0;
         at_top = (s_q.count == top);
         at_bot = s_q.count_down && (s_q.count == tmw_pkg::CNT_BOTTOM);
         unique case (s_q.wave_mode)
            tmw_pkg::WM_CTC: begin
               // a top below the count is missed until the wrap
               if (match[0]) begin
                  s_d.count = tmw_pkg::CNT_BOTTOM;
               end else begin
                  s_d.count = s_q.count + 8'h01;
               end
               ovf_set = (s_q.count == tmw_pkg::CNT_MAX);
            end
            tmw_pkg::WM_FAST_FULL, tmw_pkg::WM_FAST_CMPA: begin
               if (at_top) begin
                  s_d.count = tmw_pkg::CNT_BOTTOM;
               end else begin
                  s_d.count = s_q.count + 8'h01;
               end
               ovf_set = at_top;
            end
            tmw_pkg::WM_PC_FULL, tmw_pkg::WM_PC_CMPA: begin
               if (!s_q.count_down) begin
                  if (at_top && (top != tmw_pkg::CNT_BOTTOM)) begin
                     s_d.count_down = 1'b1;
                     s_d.count      = s_q.count - 8'h01;
                  end else if (!at_top) begin
                     s_d.count = s_q.count + 8'h01;
                  end
               end else if (at_bot) begin
                  s_d.count_down = 1'b0;
                  s_d.count      = s_q.count + 8'h01;
               end else begin
                  s_d.count = s_q.count - 8'h01;
               end
               // a zero top parks the count at bottom, and each parked tick still counts as reaching zero
               ovf_set = at_bot || (at_top && (top == tmw_pkg::CNT_BOTTOM));
            end
            default: begin
               // normal mode, and the unused codes 4 and 6 alike
               s_d.count = s_q.count + 8'h01;
               ovf_set   = (s_q.count == tmw_pkg::CNT_MAX);
            end
         endcase
         if (ovf_set) begin
            s_d.ovf_flag = 1'b1;
         end

         // compare channels: flags, then wave actions by mode
         for (int ch = 0; ch < 2; ch++) begin
            if (match[ch]) begin
               s_d.match_flag[ch] = 1'b1;
            end
            // in pwm clear and set modes a compare equal to top leaves the work to the bottom action
            ignore     = pwm && s_q.out_mode[ch][1] && (s_q.cmp_act[ch] == top);
            // toggle in pwm only for channel a with compare-a top
            can_toggle = !pwm || ((ch == 0) && s_q.wave_mode[2]);
            if (match[ch] && !ignore) begin
               unique case (s_q.out_mode[ch])
                  tmw_pkg::COM_TOGGLE: begin
                     if (can_toggle) begin
                        s_d.wave[ch] = !s_q.wave[ch];
                     end
                  end
                  tmw_pkg::COM_CLEAR: s_d.wave[ch] = pc && s_q.count_down;
                  tmw_pkg::COM_SET:   s_d.wave[ch] = !(pc && s_q.count_down);
                  tmw_pkg::COM_OFF:   s_d.wave[ch] = s_q.wave[ch];
               endcase
            end
            // bottom action wins over a match in the same tick
            if (fast && at_top && s_q.out_mode[ch][1]) begin
               s_d.wave[ch] = !s_q.out_mode[ch][0];
            end
            // start of a dual-slope period restores the pre-match level
            if (pc && at_bot && s_q.out_mode[ch][1]) begin
               s_d.wave[ch] = (s_q.cmp_act[ch] != tmw_pkg::CNT_BOTTOM) ^ s_q.out_mode[ch][0];
            end
            // double buffer reloads at top so pulses never come out odd
            if (pwm && at_top) begin
               s_d.cmp_act[ch] = s_q.cmp_buf[ch];
            end
         end
      end

      // software writes override counting
      if (wr_en) begin
         case (paddr_i)
            tmw_pkg::ADDR_CTRL: begin
               s_d.wave_mode   = tmw_pkg::tmw_wave_mode_t'(pwdata_i[tmw_pkg::CTRL_WAVE_LSB +: 3]);
               s_d.clk_sel     = pwdata_i[tmw_pkg::CTRL_CS_LSB +: 3];
               s_d.out_mode[0] = tmw_pkg::tmw_out_mode_t'(pwdata_i[tmw_pkg::CTRL_COMA_LSB +: 2]);
               s_d.out_mode[1] = tmw_pkg::tmw_out_mode_t'(pwdata_i[tmw_pkg::CTRL_COMB_LSB +: 2]);
               s_d.wave_en[0]  = pwdata_i[tmw_pkg::CTRL_COMA_LSB +: 2] != 2'h0;
               s_d.wave_en[1]  = pwdata_i[tmw_pkg::CTRL_COMB_LSB +: 2] != 2'h0;
            end
            tmw_pkg::ADDR_COUNT: begin
               // the written value must not fire a match on the next tick
               s_d.count       = pwdata_i[7:0];
               s_d.match_block = 1'b1;
            end
            tmw_pkg::ADDR_CMPA, tmw_pkg::ADDR_CMPB: begin
               s_d.cmp_buf[paddr_i[2]] = pwdata_i[7:0];
               if (!pwm) begin
                  s_d.cmp_act[paddr_i[2]] = pwdata_i[7:0];
               end
            end
            tmw_pkg::ADDR_FLAGS: begin
               // write one clears; an event in the same cycle wins
               if (pwdata_i[tmw_pkg::FLAG_OVF] && !ovf_set) begin
                  s_d.ovf_flag = 1'b0;
               end
               for (int ch = 0; ch < 2; ch++) begin
                  if (pwdata_i[tmw_pkg::FLAG_MATCH_A + ch] && !(tick && match[ch])) begin
                     s_d.match_flag[ch] = 1'b0;
                  end
               end
            end
            default: s_d.prdata = s_d.prdata;
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state flops
   assign prdata_o        = s_q.prdata;
   assign pready_o        = s_q.pready;
   assign pslverr_o       = s_q.pslverr;
   assign wave_out_a_o    = s_q.wave[0];
   assign wave_out_b_o    = s_q.wave[1];
   assign wave_en_a_o     = s_q.wave_en[0];  // pin also needs its direction set
   assign wave_en_b_o     = s_q.wave_en[1];
   assign overflow_flag_o = s_q.ovf_flag;
   assign match_flag_a_o  = s_q.match_flag[0];
   assign match_flag_b_o  = s_q.match_flag[1];
   assign count_value_o   = s_q.count;

   // ------------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------------
   property p_normal_wrap;
      @(posedge clock_i) disable iff (!reset_n_i)
      tick && (s_q.wave_mode == tmw_pkg::WM_NORMAL) && (s_q.count == 8'hff) && !wr_en
      |=> (s_q.count == 8'h00) && s_q.ovf_flag;
   endproperty
   a_normal_wrap: assert property (p_normal_wrap) else $error("normal mode did not wrap with overflow");

   property p_ctc_clear;
      @(posedge clock_i) disable iff (!reset_n_i)
      tick && (s_q.wave_mode == tmw_pkg::WM_CTC) && match[0] && !wr_en
      |=> (s_q.count == 8'h00) && s_q.match_flag[0];
   endproperty
   a_ctc_clear: assert property (p_ctc_clear) else $error("ctc match did not clear count and flag");

   property p_ctc_toggle;
      @(posedge clock_i) disable iff (!reset_n_i)
      tick && (s_q.wave_mode == tmw_pkg::WM_CTC) && match[0] && (s_q.out_mode[0] == tmw_pkg::COM_TOGGLE)
      |=> s_q.wave[0] != $past(s_q.wave[0]);
   endproperty
   a_ctc_toggle: assert property (p_ctc_toggle) else $error("ctc toggle did not toggle output a");

   property p_fast_restart;
      @(posedge clock_i) disable iff (!reset_n_i)
      tick && mode_is_fast(s_q.wave_mode) && (s_q.count == top) && !wr_en
      |=> (s_q.count == 8'h00) && s_q.ovf_flag;
   endproperty
   a_fast_restart: assert property (p_fast_restart) else $error("fast pwm did not restart at top");

   property p_fast_bottom_set;
      @(posedge clock_i) disable iff (!reset_n_i)
      tick && mode_is_fast(s_q.wave_mode) && (s_q.count == top) && (s_q.out_mode[0] == tmw_pkg::COM_CLEAR) && !wr_en
      |=> (s_q.wave[0] and ((tick && match[0] && (s_q.cmp_act[0] != top) && !wr_en) |=> !s_q.wave[0]));
   endproperty
   a_fast_bottom_set: assert property (p_fast_bottom_set) else $error("fast pwm bottom level wrong");

   property p_pc_top_hold;
      @(posedge clock_i) disable iff (!reset_n_i)
      tick && mode_is_pc(s_q.wave_mode) && !s_q.count_down && (s_q.count == top) && (top != 8'h00) && !wr_en
      |=> s_q.count_down && (s_q.count == $past(s_q.count) - 8'h01);
   endproperty
   a_pc_top_hold: assert property (p_pc_top_hold) else $error("phase correct did not reverse after one top tick");

   property p_pc_bottom;
      @(posedge clock_i) disable iff (!reset_n_i)
      tick && mode_is_pc(s_q.wave_mode) && s_q.count_down && (s_q.count == 8'h00)
           && (s_q.out_mode[0] == tmw_pkg::COM_CLEAR) && !wr_en
      |=> s_q.ovf_flag && !s_q.count_down && (s_q.wave[0] == ($past(s_q.cmp_act[0]) != 8'h00));
   endproperty
   a_pc_bottom: assert property (p_pc_bottom) else $error("phase correct bottom handling wrong");

   property p_stopped;
      @(posedge clock_i) disable iff (!reset_n_i)
      (s_q.clk_sel == 3'h0) && !wr_en |=> $stable(s_q.count);
   endproperty
   a_stopped: assert property (p_stopped) else $error("count moved while stopped");

   property p_pwm_buffered;
      @(posedge clock_i) disable iff (!reset_n_i)
      mode_is_pwm(s_q.wave_mode) && !(tick && (s_q.count == top)) && !(wr_en && paddr_i == tmw_pkg::ADDR_CTRL)
      |=> $stable(s_q.cmp_act);
   endproperty
   a_pwm_buffered: assert property (p_pwm_buffered) else $error("pwm compare changed away from top");

endmodule
`default_nettype wire
